//--- design/ssh_pkg.sv
`default_nettype none
package ssh_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses, one aligned word each
  localparam logic [7:0] OFF_RX_DATA = 8'h00;
  localparam logic [7:0] OFF_RX_STAT = 8'h04;
  localparam logic [7:0] OFF_DIV_LO  = 8'h08;
  localparam logic [7:0] OFF_DIV_HI  = 8'h0c;
  localparam logic [7:0] OFF_TX_STAT = 8'h10;
  localparam logic [7:0] OFF_RATE    = 8'h14;
  localparam logic [7:0] OFF_TX_HOLD = 8'h18;
  localparam logic [7:0] OFF_INT_EN  = 8'h1c;
  localparam logic [7:0] OFF_FLAGS   = 8'h20;

  // receive_status_control fields
  localparam int RX_PORT_ENABLE = 7;
  localparam int RX_RX9  = 6;
  localparam int RX_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RX_FRAMING_FLAG = 2;
  localparam int RX_OVERRUN_FLAG = 1;
  localparam int RX_9D   = 0;

  // transmit_status_control fields
  localparam int TX_CLOCK_SOURCE_SELECT = 7;
  localparam int TX_TX9  = 6;
  localparam int TX_TXEN = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_HIGH_SPEED_SELECT = 2;
  localparam int TX_TRMT = 1;
  localparam int TX_9D   = 0;

  // rate_and_polarity_control fields
  localparam int RATE_IDLE = 6;
  localparam int RATE_WIDE = 3;

  // Interrupt enable and flag fields
  localparam int IE_RC = 0;
  localparam int IE_TX = 1;
  localparam int IE_PE = 2;
  localparam int IE_GL = 3;
  localparam int FL_RC = 0;
  localparam int FL_TX = 1;

  // Reset value of every software register
  localparam logic [7:0] REG_RESET = 8'h00;

  // Character lengths, buffer depth and rate prescale
  localparam logic [3:0] BITS_8        = 4'h8;
  localparam logic [3:0] BITS_9        = 4'h9;
  localparam logic [1:0] FIFO_DEPTH    = 2'h2;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
endpackage : ssh_pkg
`default_nettype wire

//--- design/ssh_pin_sync.sv
`default_nettype none
module ssh_pin_sync (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);
  import ssh_pkg::*;

  typedef struct packed {
    logic meta;
    logic lvl;
    logic prev;
  } ssh_sync_s;

  ssh_sync_s s;
  ssh_sync_s next_s;

  // Two flops, then a third copy for edge detection off the clean level
  always_comb begin
    next_s      = s;
    next_s.meta = i_pin;
    next_s.lvl  = s.meta;
    next_s.prev = s.lvl;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Edges seen only on the settled copies, never on the first flop
  assign o_level = s.lvl;
  assign o_rise  = s.lvl & ~s.prev;
  assign o_fall  = ~s.lvl & s.prev;
endmodule : ssh_pin_sync
`default_nettype wire

//--- design/ssh_rate_div.sv
`default_nettype none
module ssh_rate_div #(
  parameter int CNT_W = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_run,
  input  wire logic             i_fast,
  input  wire logic [CNT_W-1:0] i_divisor,
  output logic                  o_tick
);
  import ssh_pkg::*;

  // The divisor pair needs at least a full byte of count
  if (CNT_W < 8) begin : g_bad_width
    $error("ssh_rate_div: CNT_W below 8");
  end

  typedef struct packed {
    logic [1:0]       pre;
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } ssh_div_s;

  ssh_div_s s;
  ssh_div_s next_s;

  // Slow rate divides by four first; stopping restarts a full period
  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (!i_run) begin
      next_s.pre = '0;
      next_s.cnt = '0;
    end else if (i_fast || s.pre == PRESCALE_LAST) begin
      next_s.pre = '0;
      if (s.cnt == i_divisor) begin
        next_s.cnt  = '0;
        next_s.tick = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 1'b1;
      end
    end else begin
      next_s.pre = s.pre + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_tick = s.tick;
endmodule : ssh_rate_div
`default_nettype wire

//--- design/ssh_serial_port.sv
`default_nettype none
// Notes on behaviour
// - Host shift rate comes from divisor pair, scaled by speed and width bits
// - Clocked mode, port enable and clock source set: host drives clock
// - Setting single or continuous receive enable starts host reception
// - Full character sets receive-complete flag; interrupt if enabled
// - Nine-bit select receives nine bits; ninth bit shown in status
// - Receive data read returns low eight bits of the character
// - Overrun clears by dropping continuous receive or port enable
// - Clocked mode with clock source clear: client, clock from pin
// - Client transmits when both receive enables clear, else receives
// - Port works only while port enable is set
// - Client transmit equals host transmit apart from sleep behaviour
// - First of two queued words moves to shift register at once
// - Second word waits in holding; buffer-empty flag stays clear
// - After first word shifts out, second moves and flag sets
// - Transmit flag with enables wakes core; global enable vectors
// - Single receive clocks one character then clears itself
// - Continuous receive runs until cleared; clearing drops partial char
// - Data pin sampled on trailing clock edge into receive shifter
// - Two-character buffer; third character sets overrun, blocks reception
module ssh_serial_port (
  input  wire logic                      I_SYS_CLK,
  input  wire logic                      I_SYS_RST,
  input  wire logic                      I_PSEL,
  input  wire logic                      I_PENABLE,
  input  wire logic                      I_PWRITE,
  input  wire logic [ssh_pkg::ADDR_W-1:0] I_PADDR,
  input  wire logic [ssh_pkg::DATA_W-1:0] I_PWDATA,
  output logic      [ssh_pkg::DATA_W-1:0] O_PRDATA,
  output logic                           O_PREADY,
  output logic                           O_PSLVERR,
  input  wire logic                      I_CLK_PIN,
  output logic                           O_CLK_PIN,
  output logic                           O_CLK_PIN_OE,
  input  wire logic                      I_DATA_PIN,
  output logic                           O_DATA_PIN,
  output logic                           O_DATA_PIN_OE,
  input  wire logic                      I_CORE_SLEEP,
  output logic                           O_INT_REQ,
  output logic                           O_WAKE
);
  import ssh_pkg::*;

  // Whole state of the port
  typedef struct packed {
    logic             port_enable;
    logic             rx9;
    logic             single_receive_enable;
    logic             continuous_receive_enable;
    logic             overrun_flag;
    logic             clock_source_select;
    logic             tx9;
    logic             txen;
    logic             sync;
    logic             high_speed_select;
    logic             tx9d;
    logic             wide_divisor_select;
    logic [7:0]       div_lo;
    logic [7:0]       div_hi;
    logic             rcie;
    logic             txie;
    logic             peie;
    logic             gie;
    logic [1:0][8:0]  fifo;
    logic [1:0]       fcnt;
    logic             frd;
    logic [8:0]       receive_shift_register;
    logic [3:0]       rbits;
    logic [8:0]       hold;
    logic             hold_full;
    logic [8:0]       transmit_shift_register;
    logic             tx_busy;
    logic [3:0]       tbits;
    logic             dout;
    logic             ck;
    logic [31:0]      prdata;
  } ssh_port_s;

  ssh_port_s s;
  ssh_port_s next_s;

  logic [1:0]  pin_raw;
  logic [1:0]  pin_lvl;
  logic [1:0]  pin_rise;
  logic [1:0]  pin_fall;
  logic        tick;
  logic        host_run;
  logic        rx_mode;
  logic        active;
  logic        lead;
  logic        trail;
  logic        rd_acc;
  logic        wr_acc;
  logic        rcif;
  logic        txif;
  logic        irq_src;
  logic [15:0] divisor;
  logic [31:0] rd_word;

  // Address match, shared by the read mux, writes and error answer
  function automatic logic is_reg(input logic [7:0] addr,
                                  input logic [7:0] off);
    is_reg = (addr == off);
  endfunction : is_reg

  function automatic logic mapped(input logic [7:0] addr);
    mapped = is_reg(addr, OFF_RX_DATA) | is_reg(addr, OFF_RX_STAT) |
             is_reg(addr, OFF_DIV_LO)  | is_reg(addr, OFF_DIV_HI)  |
             is_reg(addr, OFF_TX_STAT) | is_reg(addr, OFF_RATE)    |
             is_reg(addr, OFF_TX_HOLD) | is_reg(addr, OFF_INT_EN)  |
             is_reg(addr, OFF_FLAGS);
  endfunction : mapped

  // Index 0 is the clock pin, index 1 the data pin
  assign pin_raw = {I_DATA_PIN, I_CLK_PIN};

  // Both pins cross in from the peer's timing before any use
  for (genvar g = 0; g < 2; g++) begin : g_pin
    ssh_pin_sync u_sync (
      .i_clk   (I_SYS_CLK),
      .i_rst   (I_SYS_RST),
      .i_pin   (pin_raw[g]),
      .o_level (pin_lvl[g]),
      .o_rise  (pin_rise[g]),
      .o_fall  (pin_fall[g])
    );
  end

  // Wide select uses both divisor bytes, otherwise low byte only
  assign divisor = s.wide_divisor_select ? {s.div_hi, s.div_lo} : {8'h00, s.div_lo};

  ssh_rate_div #(
    .CNT_W (16)
  ) u_div (
    .i_clk     (I_SYS_CLK),
    .i_rst     (I_SYS_RST),
    .i_run     (host_run),
    .i_fast    (s.high_speed_select),
    .i_divisor (divisor),
    .o_tick    (tick)
  );

  // Mode decode; a disabled port neither shifts nor drives its pins
  assign active  = s.port_enable & s.sync;
  assign rx_mode = s.single_receive_enable | s.continuous_receive_enable;
  // Host clocks run while a reception is wanted and not blocked,
  // or while a transmit word is shifting
  assign host_run = active & s.clock_source_select &
                    (rx_mode ? ~s.overrun_flag : s.tx_busy);
  // Edges: own toggling clock as host, synchronised pin as client
  assign lead  = s.clock_source_select ? (tick & ~s.ck) : pin_rise[0];
  assign trail = s.clock_source_select ? (tick & s.ck)  : pin_fall[0];

  // Bus phases; side effects happen only in the access phase
  assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd_acc = I_PSEL & I_PENABLE & ~I_PWRITE;

  assign rcif = (s.fcnt != 2'h0);
  assign txif = ~s.hold_full;

  // Read mux; sampled in the setup cycle so data comes from a flop
  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_reg(I_PADDR, OFF_RX_DATA)) begin
      rd_word[7:0] = s.fifo[s.frd][7:0];
    end else if (is_reg(I_PADDR, OFF_RX_STAT)) begin
      rd_word[RX_PORT_ENABLE] = s.port_enable;
      rd_word[RX_RX9]  = s.rx9;
      rd_word[RX_SINGLE_RECEIVE_ENABLE] = s.single_receive_enable;
      rd_word[RX_CONTINUOUS_RECEIVE_ENABLE] = s.continuous_receive_enable;
      rd_word[RX_OVERRUN_FLAG] = s.overrun_flag;
      rd_word[RX_9D]   = s.fifo[s.frd][8];
    end else if (is_reg(I_PADDR, OFF_DIV_LO)) begin
      rd_word[7:0] = s.div_lo;
    end else if (is_reg(I_PADDR, OFF_DIV_HI)) begin
      rd_word[7:0] = s.div_hi;
    end else if (is_reg(I_PADDR, OFF_TX_STAT)) begin
      rd_word[TX_CLOCK_SOURCE_SELECT] = s.clock_source_select;
      rd_word[TX_TX9]  = s.tx9;
      rd_word[TX_TXEN] = s.txen;
      rd_word[TX_SYNC] = s.sync;
      rd_word[TX_HIGH_SPEED_SELECT] = s.high_speed_select;
      rd_word[TX_TRMT] = ~s.tx_busy;
      rd_word[TX_9D]   = s.tx9d;
    end else if (is_reg(I_PADDR, OFF_RATE)) begin
      rd_word[RATE_IDLE] = (s.rbits == 4'h0);
      rd_word[RATE_WIDE] = s.wide_divisor_select;
    end else if (is_reg(I_PADDR, OFF_INT_EN)) begin
      rd_word[IE_RC] = s.rcie;
      rd_word[IE_TX] = s.txie;
      rd_word[IE_PE] = s.peie;
      rd_word[IE_GL] = s.gie;
    end else if (is_reg(I_PADDR, OFF_FLAGS)) begin
      rd_word[FL_RC] = rcif;
      rd_word[FL_TX] = txif;
    end
  end

  // Next-state logic: software first, then the shift engines, port-enable clear last,
  // so a hardware set in the same cycle wins over a clear, except the port-enable clear
  always_comb begin
    logic [3:0] nbits;
    logic [3:0] tbits;
    logic [8:0] shifted;
    logic [8:0] chr;
    logic       wptr;
    nbits   = s.rx9 ? BITS_9 : BITS_8;
    tbits   = s.tx9 ? BITS_9 : BITS_8;
    shifted = '0;
    chr     = '0;
    wptr    = 1'b0;
    next_s  = s;

    if (I_PSEL & ~I_PENABLE & ~I_PWRITE) begin
      next_s.prdata = rd_word;
    end

    // Register writes
    if (wr_acc) begin
      if (is_reg(I_PADDR, OFF_RX_STAT)) begin
        next_s.port_enable = I_PWDATA[RX_PORT_ENABLE];
        next_s.rx9  = I_PWDATA[RX_RX9];
        next_s.single_receive_enable = I_PWDATA[RX_SINGLE_RECEIVE_ENABLE];
        next_s.continuous_receive_enable = I_PWDATA[RX_CONTINUOUS_RECEIVE_ENABLE];
      end
      if (is_reg(I_PADDR, OFF_DIV_LO)) begin
        next_s.div_lo = I_PWDATA[7:0];
      end
      if (is_reg(I_PADDR, OFF_DIV_HI)) begin
        next_s.div_hi = I_PWDATA[7:0];
      end
      if (is_reg(I_PADDR, OFF_TX_STAT)) begin
        next_s.clock_source_select = I_PWDATA[TX_CLOCK_SOURCE_SELECT];
        next_s.tx9  = I_PWDATA[TX_TX9];
        next_s.txen = I_PWDATA[TX_TXEN];
        next_s.sync = I_PWDATA[TX_SYNC];
        next_s.high_speed_select = I_PWDATA[TX_HIGH_SPEED_SELECT];
        next_s.tx9d = I_PWDATA[TX_9D];
      end
      if (is_reg(I_PADDR, OFF_RATE)) begin
        next_s.wide_divisor_select = I_PWDATA[RATE_WIDE];
      end
      if (is_reg(I_PADDR, OFF_INT_EN)) begin
        next_s.rcie = I_PWDATA[IE_RC];
        next_s.txie = I_PWDATA[IE_TX];
        next_s.peie = I_PWDATA[IE_PE];
        next_s.gie  = I_PWDATA[IE_GL];
      end
      // A full holding word is overwritten; software should poll first
      if (is_reg(I_PADDR, OFF_TX_HOLD)) begin
        next_s.hold      = {s.tx9d, I_PWDATA[7:0]};
        next_s.hold_full = 1'b1;
      end
    end

    // Reading the data register pops the buffer
    if (rd_acc && is_reg(I_PADDR, OFF_RX_DATA) && rcif) begin
      next_s.frd  = ~s.frd;
      next_s.fcnt = s.fcnt - 2'h1;
      if (!s.continuous_receive_enable) begin
        next_s.overrun_flag = 1'b0; // single-receive overrun ends on a read
      end
    end

    // Dropping continuous receive clears overrun and the partial char
    if (s.continuous_receive_enable && !next_s.continuous_receive_enable) begin
      next_s.overrun_flag  = 1'b0;
      next_s.rbits = 4'h0;
      next_s.receive_shift_register   = '0;
    end

    // Host clock toggles each half period and parks low when stopped
    if (!host_run) begin
      next_s.ck = 1'b0;
    end else if (tick) begin
      next_s.ck = ~s.ck;
    end

    // Receive engine, LSB first, sampled on trailing edges
    if (active && rx_mode && s.continuous_receive_enable == next_s.continuous_receive_enable && !s.overrun_flag &&
        trail) begin
      shifted = {pin_lvl[1], s.receive_shift_register[8:1]};
      if (s.rbits + 4'h1 == nbits) begin
        chr          = s.rx9 ? shifted : {1'b0, shifted[8:1]};
        next_s.receive_shift_register   = '0;
        next_s.rbits = 4'h0;
        if (next_s.fcnt < FIFO_DEPTH) begin
          wptr                = next_s.frd ^ next_s.fcnt[0];
          next_s.fifo[wptr]   = chr;
          next_s.fcnt         = next_s.fcnt + 2'h1;
        end else begin
          next_s.overrun_flag = 1'b1;
        end
        if (!s.continuous_receive_enable) begin
          next_s.single_receive_enable = 1'b0;
        end
      end else begin
        next_s.receive_shift_register   = shifted;
        next_s.rbits = s.rbits + 4'h1;
      end
    end

    // Transmit engine: load, drive on leading, count on trailing
    if (active && !rx_mode && s.txen) begin
      if (!s.tx_busy && s.hold_full) begin
        next_s.transmit_shift_register       = s.hold;
        // A word written in this same cycle stays queued, never lost
        next_s.hold_full = wr_acc && is_reg(I_PADDR, OFF_TX_HOLD);
        next_s.tx_busy   = 1'b1;
        next_s.tbits     = 4'h0;
        next_s.dout      = s.hold[0];
      end else if (s.tx_busy && lead) begin
        next_s.dout = s.transmit_shift_register[0];
      end else if (s.tx_busy && trail) begin
        next_s.transmit_shift_register = {1'b0, s.transmit_shift_register[8:1]};
        if (s.tbits + 4'h1 == tbits) begin
          next_s.tx_busy = 1'b0;
          next_s.tbits   = 4'h0;
        end else begin
          next_s.tbits = s.tbits + 4'h1;
        end
      end
    end

    // Clearing port enable resets every moving part of the port
    if (!next_s.port_enable) begin
      next_s.overrun_flag      = 1'b0;
      next_s.fcnt      = 2'h0;
      next_s.frd       = 1'b0;
      next_s.receive_shift_register       = '0;
      next_s.rbits     = 4'h0;
      next_s.hold_full = 1'b0;
      next_s.tx_busy   = 1'b0;
      next_s.tbits     = 4'h0;
      next_s.dout      = 1'b0;
      next_s.ck        = 1'b0;
    end
  end

  // All registers reset to REG_RESET; runtime state to zero
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      s        <= '0;
      s.div_lo <= REG_RESET;
      s.div_hi <= REG_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Zero-wait slave; read data already captured in the setup cycle
  assign O_PRDATA  = s.prdata;
  assign O_PREADY  = I_PSEL & I_PENABLE;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped(I_PADDR);

  // Only a host drives the clock; the data pin is driven only to send
  assign O_CLK_PIN     = s.ck;
  assign O_CLK_PIN_OE  = active & s.clock_source_select;
  assign O_DATA_PIN    = s.dout;
  assign O_DATA_PIN_OE = active & ~rx_mode & s.txen;

  // Request lines toward the core's interrupt controller
  assign irq_src   = (rcif & s.rcie) | (txif & s.txie);
  assign O_WAKE    = irq_src & s.peie & I_CORE_SLEEP;
  assign O_INT_REQ = irq_src & s.peie & s.gie;
endmodule : ssh_serial_port
`default_nettype wire

//--- verification/ssh_assertions.sv
`default_nettype none
module ssh_assertions (
  input wire logic                       I_SYS_CLK,
  input wire logic                       I_SYS_RST,
  input wire logic                       I_PSEL,
  input wire logic                       I_PENABLE,
  input wire logic                       I_PWRITE,
  input wire logic [ssh_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [ssh_pkg::DATA_W-1:0] I_PWDATA,
  input wire logic                       O_CLK_PIN,
  input wire logic                       O_CLK_PIN_OE,
  input wire logic                       O_DATA_PIN_OE,
  input wire logic                       I_CORE_SLEEP,
  input wire logic                       O_INT_REQ,
  input wire logic                       O_WAKE
);
  timeunit 1ns;
  timeprecision 1ns;
  import ssh_pkg::*;
  logic [7:0]  rxs, txs, dlo, dhi, rte, ien;
  logic [19:0] cnt, half;
  logic        clk_d, armed, host, client;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);

  // Shadow of software writes; the real registers are not ports
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      {rxs, txs, dlo, dhi, rte, ien} <= '0;
    end else if (I_PSEL && I_PENABLE && I_PWRITE) begin
      case (I_PADDR)
        OFF_RX_STAT: rxs <= I_PWDATA[7:0];
        OFF_TX_STAT: txs <= I_PWDATA[7:0];
        OFF_DIV_LO:  dlo <= I_PWDATA[7:0];
        OFF_DIV_HI:  dhi <= I_PWDATA[7:0];
        OFF_RATE:    rte <= I_PWDATA[7:0];
        OFF_INT_EN:  ien <= I_PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // Mode decode and expected half period of the host clock
  assign host   = rxs[RX_PORT_ENABLE] & txs[TX_SYNC] & txs[TX_CLOCK_SOURCE_SELECT];
  assign client = rxs[RX_PORT_ENABLE] & txs[TX_SYNC] & ~txs[TX_CLOCK_SOURCE_SELECT];
  assign half   = ({4'h0, (rte[RATE_WIDE] ? dhi : 8'h00), dlo} + 20'h1)
                * (txs[TX_HIGH_SPEED_SELECT] ? 20'h1 : 20'h4);

  // Cycles since the clock pin moved; a gap longer than half disarms,
  // so pauses between characters never read as a wrong rate
  always_ff @(posedge I_SYS_CLK) begin
    clk_d <= O_CLK_PIN;
    if (I_SYS_RST || O_CLK_PIN != clk_d) begin
      cnt   <= 20'h0;
      armed <= !I_SYS_RST;
    end else begin
      cnt <= cnt + 20'h1;
      if (cnt >= half - 20'h1)
        armed <= 1'b0;
    end
  end

  property p_half;
    host && armed && $changed(O_CLK_PIN) |-> cnt == half - 20'h1;
  endproperty
  a_half: assert property (p_half) else $error("clock half period");
  property p_host_oe;
    host [*3] |-> O_CLK_PIN_OE;
  endproperty
  a_host_oe: assert property (p_host_oe) else $error("host idle clk");
  property p_client_oe;
    client [*3] |-> !O_CLK_PIN_OE;
  endproperty
  a_client_oe: assert property (p_client_oe) else $error("client clk");
  property p_off;
    (!rxs[RX_PORT_ENABLE]) [*3] |-> !O_CLK_PIN_OE && !O_DATA_PIN_OE;
  endproperty
  a_off: assert property (p_off) else $error("port off drives");
  property p_rx_dir;
    rxs[RX_CONTINUOUS_RECEIVE_ENABLE] [*3] |-> !O_DATA_PIN_OE;
  endproperty
  a_rx_dir: assert property (p_rx_dir) else $error("rx drives data");
  property p_tx_dir;
    (client && txs[TX_TXEN] && !rxs[RX_SINGLE_RECEIVE_ENABLE] && !rxs[RX_CONTINUOUS_RECEIVE_ENABLE]) [*3]
      |-> O_DATA_PIN_OE;
  endproperty
  a_tx_dir: assert property (p_tx_dir) else $error("tx data idle");
  property p_wake;
    O_WAKE |-> I_CORE_SLEEP && ien[IE_PE] && (ien[IE_TX] || ien[IE_RC]);
  endproperty
  a_wake: assert property (p_wake) else $error("wake not enabled");
  property p_int;
    O_INT_REQ |-> ien[IE_GL] && ien[IE_PE];
  endproperty
  a_int: assert property (p_int) else $error("int not enabled");
endmodule : ssh_assertions

bind ssh_serial_port ssh_assertions u_chk (.*);
`default_nettype wire

//--- verification/ssh_peer.sv
`default_nettype none
module ssh_peer (
  input  wire logic i_clk_line,
  input  wire logic i_data_line,
  output logic      o_clk,
  output logic      o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0]  word;
  logic [15:0] rx_cap;
  int          len;
  int          nbit;

  initial begin
    {o_clk, o_data, word, rx_cap, nbit} = '0;
    len = 8;
  end

  // New bit on each leading edge, LSB first, settled by the trailing edge
  always @(posedge i_clk_line) begin
    o_data <= word[nbit];
    nbit   <= (nbit + 1 == len) ? 0 : nbit + 1;
  end

  task automatic load(input logic [8:0] w, input int n);
    word = w;
    len  = n;
    nbit = 0;
  endtask : load

  // Client clock, 800 ns period, low between frames; samples on each
  // trailing edge, since a freshly loaded word may move data before
  // the next leading edge
  task automatic clock_out(input int n);
    #37;
    repeat (n) begin
      o_clk = 1'b1;
      #400 rx_cap = {i_data_line, rx_cap[15:1]};
      o_clk = 1'b0;
      #400;
    end
  endtask : clock_out
endmodule : ssh_peer
`default_nettype wire

//--- verification/tb_top.sv
`default_nettype none
`define CHK(a, e) begin \
  n_checks++; \
  if ((a) !== (e)) begin \
    mismatches++; \
    $display("Error at %0t got %h exp %h", $time, (a), (e)); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ssh_pkg::*;
  logic        clk, rst, psel, penable, pwrite, sleep, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, ck_o, ck_oe, dt_o, dt_oe, int_req, wake;
  logic        peer_ck, peer_dt;
  wire         ck_line, dt_line;
  int          mismatches, n_checks;

  // Pin levels: the device wins while it drives, else the peer; no
  // general output driver or analog function sits on either pin
  assign ck_line = ck_oe ? ck_o : peer_ck;
  assign dt_line = dt_oe ? dt_o : peer_dt;

  ssh_serial_port dut (
    .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_CLK_PIN(ck_line), .O_CLK_PIN(ck_o), .O_CLK_PIN_OE(ck_oe),
    .I_DATA_PIN(dt_line), .O_DATA_PIN(dt_o), .O_DATA_PIN_OE(dt_oe),
    .I_CORE_SLEEP(sleep), .O_INT_REQ(int_req), .O_WAKE(wake)
  );
  ssh_peer peer (
    .i_clk_line(ck_line), .i_data_line(dt_line),
    .o_clk(peer_ck), .o_data(peer_dt)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : chk

  // Polls a status bit with a bounded number of reads
  task automatic wait_bit(input logic [7:0] a, input int b);
    for (int k = 0; k < 300; k++) begin
      apb(1'b0, a, 32'h0);
      if (rd[b] === 1'b1) break;
    end
  endtask : wait_bit

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // Whole run is under a thousand cycles; this bound cuts a hang
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial begin
    {psel, penable, pwrite, sleep} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset contents: shifter empty, receiver idle, holding empty
    for (int i = 0; i <= 8; i++)
      chk(8'(4 * i), (i == 4 || i == 8) ? 32'h2 : (i == 5) ? 32'h40 : 32'h0);
    chk(8'h24, 32'h0);
    `CHK(err, 1'b1)
    // Host single receive, half period of four cycles
    wr(OFF_DIV_LO, 8'h03);
    wr(OFF_DIV_HI, 8'hff);
    wr(OFF_TX_STAT, 8'h94);
    wr(OFF_INT_EN, 8'h0d);
    wr(OFF_RX_STAT, 8'h80);
    peer.load(9'h0a5, 8);
    wr(OFF_RX_STAT, 8'ha0);
    wait_bit(OFF_FLAGS, FL_RC);
    `CHK(int_req, 1'b1)
    chk(OFF_RX_STAT, 32'h80);
    chk(OFF_RX_DATA, 32'ha5);
    // Nine-bit character on the slow prescale, status read before data
    wr(OFF_DIV_LO, 8'h00);
    wr(OFF_TX_STAT, 8'h90);
    peer.load(9'h15a, 9);
    wr(OFF_RX_STAT, 8'he0);
    wait_bit(OFF_FLAGS, FL_RC);
    chk(OFF_RX_STAT, 32'hc1);
    chk(OFF_RX_DATA, 32'h5a);
    chk(OFF_FLAGS, 32'h2);
    // Continuous receive into a full buffer, then recovery
    wr(OFF_DIV_HI, 8'h00);
    wr(OFF_DIV_LO, 8'h03);
    wr(OFF_RATE, 8'h08);
    wr(OFF_TX_STAT, 8'h94);
    peer.load(9'h03c, 8);
    wr(OFF_RX_STAT, 8'h90);
    wait_bit(OFF_RX_STAT, RX_OVERRUN_FLAG);
    chk(OFF_RX_STAT, 32'h92);
    repeat (2) chk(OFF_RX_DATA, 32'h3c);
    wr(OFF_RX_STAT, 8'h80);
    chk(OFF_RX_STAT, 32'h80);
    chk(OFF_RATE, 32'h48);
    chk(OFF_FLAGS, 32'h2);
    // Client transmit of two queued words while the core sleeps
    wr(OFF_RX_STAT, 8'h00);
    wr(OFF_TX_STAT, 8'h30);
    wr(OFF_RX_STAT, 8'h80);
    wr(OFF_INT_EN, 8'h06);
    sleep <= 1'b1;
    wr(OFF_TX_HOLD, 8'h96);
    wr(OFF_TX_HOLD, 8'h4b);
    chk(OFF_FLAGS, 32'h0);
    `CHK(wake, 1'b0)
    peer.clock_out(8);
    repeat (4) @(posedge clk);
    chk(OFF_FLAGS, 32'h2);
    `CHK(wake, 1'b1)
    `CHK(int_req, 1'b0)
    wr(OFF_INT_EN, 8'h0e);
    @(posedge clk);
    `CHK(int_req, 1'b1)
    peer.clock_out(8);
    `CHK(peer.rx_cap, 16'h4b96)
    close_out();
  end
endmodule : tb_top
`default_nettype wire
